// ### src/mcb_bank.sv
// One error-reporting bank: status logging, overflow and fault address
`timescale 1ns/100ps
module mcb_bank #(
  parameter int ADDR_W = 40
) (
  input wire logic clock,                 // Core clock
  input wire logic rstn,                  // Async reset, active low
  input wire logic clear,                 // Post-reset clearing pulse
  input wire logic sw_wr,                 // Software write of status
  input wire logic [63:0] sw_data,        // Software status value
  input wire mcb_pkg::mcb_err_t err,      // Error report
  output logic [63:0] status_ff,          // Bank status
  output logic [ADDR_W-1:0] addr_ff       // Bank fault address
);
  initial begin
    if (ADDR_W != mcb_pkg::ADDR_W) $error("mcb_bank: ADDR_W must match the error report address width");
  end

  logic [63:0] nxt_status;
  logic [ADDR_W-1:0] nxt_addr;
  logic held_ok;

  always_comb begin
    nxt_status = status_ff;
    nxt_addr = addr_ff;
    held_ok = status_ff[mcb_pkg::VALID_BIT] && status_ff[mcb_pkg::NOT_CORRECTED_FLAG_BIT];
    if (clear) begin
      nxt_status = '0;
      nxt_addr = '0;
    end else begin
      if (sw_wr) begin
        nxt_status = sw_data;
      end
      if (err.valid) begin
        // Overflow is set on any error seen while valid, uncorrected or not, and on any second-half error
        if (status_ff[mcb_pkg::VALID_BIT] || err.second_half) begin
          nxt_status[mcb_pkg::OVER_BIT] = 1'b1;
        end
        // An uncorrected record is never replaced by a later one
        if (!held_ok) begin
          nxt_status[mcb_pkg::VALID_BIT] = 1'b1;
          nxt_status[mcb_pkg::NOT_CORRECTED_FLAG_BIT] = err.not_corrected_flag;
          nxt_status[mcb_pkg::PCC_BIT] = err.context_corrupt_flag;
          nxt_status[mcb_pkg::EN_BIT] = 1'b1;
          nxt_status[mcb_pkg::ADDRV_BIT] = err.addr_ok;
          nxt_status[mcb_pkg::CODE_LSB +: mcb_pkg::CODE_W] = err.code;
          // Address of the faulting access itself, captured with the record
          if (err.addr_ok) begin
            nxt_addr = err.addr;
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_ff <= '0;
      addr_ff <= '0;
    end else begin
      status_ff <= nxt_status;
      addr_ff <= nxt_addr;
    end
  end
endmodule

// ### src/mcb_pkg.sv
// Package of constants and carriers for the machine-check error bank
package mcb_pkg;
  localparam int STAT_W = 64;
  localparam int ADDR_W = 40;
  localparam int CODE_W = 16;
  // Status field positions
  localparam int VALID_BIT = 63;
  localparam int OVER_BIT = 62;
  localparam int NOT_CORRECTED_FLAG_BIT = 61;
  localparam int EN_BIT = 60;
  localparam int MISCV_BIT = 59;
  localparam int ADDRV_BIT = 58;
  localparam int PCC_BIT = 57;
  localparam int CODE_LSB = 0;
  // Register offsets on the plain port (word index)
  localparam logic [3:0] OFS_BANK0_CTL = 4'h0;
  localparam logic [3:0] OFS_BANK0_STAT_LO = 4'h1;
  localparam logic [3:0] OFS_BANK0_STAT_HI = 4'h2;
  localparam logic [3:0] OFS_BANK1_CTL = 4'h3;
  localparam logic [3:0] OFS_BANK1_STAT_LO = 4'h4;
  localparam logic [3:0] OFS_BANK1_STAT_HI = 4'h5;
  localparam logic [3:0] OFS_BANK1_ADDR_LO = 4'h6;
  localparam logic [3:0] OFS_BANK1_ADDR_HI = 4'h7;
  localparam logic [3:0] OFS_BANK2_CTL = 4'h8;
  localparam logic [3:0] OFS_BANK2_STAT_LO = 4'h9;
  localparam logic [3:0] OFS_BANK2_STAT_HI = 4'ha;
  localparam logic [3:0] OFS_GLOBAL = 4'hb;
  // Global control bits
  localparam int GLB_MCE_EN = 0;
  localparam int GLB_IN_HANDLER = 1;
  localparam int GLB_SMI_PEND = 2;
  localparam int GLB_CLEAR_BUSY = 3;
  localparam logic [31:0] CTL_RESET = 32'hffffffff;
  localparam int NUM_BANKS = 3;
  localparam int CLEAR_CYCLES = 8;

  // One error report into a bank
  typedef struct packed {
    logic valid;
    logic not_corrected_flag;
    logic context_corrupt_flag;
    logic second_half;
    logic addr_ok;
    logic [CODE_W-1:0] code;
    logic [ADDR_W-1:0] addr;
  } mcb_err_t;

  typedef enum logic [1:0] {
    MCB_CLEAR,
    MCB_RUN,
    MCB_HANDLER
  } mcb_state_t;
endpackage

// ### src/mcb_top.sv
// Machine-check error banks, exception raising and shared error signal
`timescale 1ns/100ps
module mcb_top #(
  parameter int ADDR_W = 40,
  parameter int CLEAR_CYCLES = mcb_pkg::CLEAR_CYCLES
) (
  input wire logic clock,                 // Core clock, 10 MHz
  input wire logic rstn,                  // Async reset, active low
  input wire logic [3:0] reg_addr,        // Register word index
  input wire logic [31:0] reg_wdata,      // Register write data
  input wire logic reg_wr,                // Write strobe
  input wire logic reg_rd,                // Read strobe
  input wire mcb_pkg::mcb_err_t l2_err,   // Bus/L2 error report
  input wire logic l2_prefetch,           // L2 report came from hardware prefetch
  input wire logic l2_multi_tag,          // Ownership request hit several tags
  input wire logic [ADDR_W-1:0] multi_tag_addr, // Address of that request
  input wire mcb_pkg::mcb_err_t l1_err,   // L1 error report
  input wire mcb_pkg::mcb_err_t b2_err,   // Bank 2 error report
  input wire logic io_data_bad,           // I/O instruction data corrupted
  input wire logic demand_hit_bad,        // Demand access hit a poisoned line
  input wire logic hard_fail,             // Hard failure response on bus
  input wire logic hard_fail_deferred,    // That transaction was deferred in snoop
  input wire logic smi_req,               // System management interrupt request
  input wire logic smi_taken,             // Core took the pending interrupt
  input wire logic handler_done,          // Exception handler returned
  input wire logic shared_err_in,         // Shared error signal level seen on bus
  output logic [31:0] reg_rdata_ff,       // Read data, cycle after the strobe
  output logic mce_ff,                    // Machine-check exception pulse to core
  output logic smi_pend_ff,               // Management interrupt pending to core
  output logic queue_retire_ff,           // Retire head of bus queue pulse
  output logic shared_err_out_ff,         // Drive shared error signal
  output logic clear_busy_ff              // Post-reset clearing in progress
);
  initial begin
    if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 255) $error("mcb_top: CLEAR_CYCLES out of range");
    if (ADDR_W != mcb_pkg::ADDR_W) $error("mcb_top: ADDR_W must match the error report address width");
  end

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  mcb_pkg::mcb_state_t state_ff, nxt_state;
  logic [7:0] clr_cnt_ff, nxt_clr_cnt;
  logic [31:0] ctl_ff [mcb_pkg::NUM_BANKS];
  logic [31:0] nxt_ctl [mcb_pkg::NUM_BANKS];
  logic mce_en_ff, nxt_mce_en;
  logic nxt_mce, nxt_smi_pend, nxt_retire, nxt_shared_out, nxt_clear_busy;
  logic [31:0] nxt_rdata;

  logic [63:0] stat [mcb_pkg::NUM_BANKS];
  logic [ADDR_W-1:0] addr [mcb_pkg::NUM_BANKS];
  mcb_pkg::mcb_err_t bank_err [mcb_pkg::NUM_BANKS];
  logic sw_wr [mcb_pkg::NUM_BANKS];
  logic [63:0] sw_data [mcb_pkg::NUM_BANKS];
  logic clearing;

  function automatic logic is_ofs(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [3:0] ctl_ofs(input int b);
    case (b)
      0: return mcb_pkg::OFS_BANK0_CTL;
      1: return mcb_pkg::OFS_BANK1_CTL;
      default: return mcb_pkg::OFS_BANK2_CTL;
    endcase
  endfunction

  function automatic logic [3:0] stat_ofs(input int b);
    case (b)
      0: return mcb_pkg::OFS_BANK0_STAT_LO;
      1: return mcb_pkg::OFS_BANK1_STAT_LO;
      default: return mcb_pkg::OFS_BANK2_STAT_LO;
    endcase
  endfunction

  assign clearing = (state_ff == mcb_pkg::MCB_CLEAR);

  // ---------------------------------------------------------------
  // Error routing into banks
  // ---------------------------------------------------------------
  always_comb begin
    bank_err[0] = l2_err;
    // Multiple tag match is logged as an uncorrected bank-0 error
    if (l2_multi_tag) begin
      bank_err[0].valid = 1'b1;
      bank_err[0].not_corrected_flag = 1'b1;
      bank_err[0].addr_ok = 1'b1;
      bank_err[0].addr = multi_tag_addr;
    end
    bank_err[1] = l1_err;
    // Bank 2 logs regardless of its control word
    bank_err[2] = b2_err;
  end

  genvar gb;
  generate
    for (gb = 0; gb < mcb_pkg::NUM_BANKS; gb++) begin : g_bank
      always_comb begin
        sw_wr[gb] = reg_wr && (is_ofs(reg_addr, stat_ofs(gb)) || is_ofs(reg_addr, stat_ofs(gb) + 4'h1));
        sw_data[gb] = stat[gb];
        if (is_ofs(reg_addr, stat_ofs(gb))) begin
          sw_data[gb][31:0] = reg_wdata;
        end else begin
          sw_data[gb][63:32] = reg_wdata;
        end
      end
      mcb_bank #(.ADDR_W(ADDR_W)) u_bank (
        .clock(clock),
        .rstn(rstn),
        .clear(clearing),
        .sw_wr(sw_wr[gb]),
        .sw_data(sw_data[gb]),
        .err(bank_err[gb]),
        .status_ff(stat[gb]),
        .addr_ff(addr[gb])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Exception raising and sequencing
  // ---------------------------------------------------------------
  logic raise;
  always_comb begin
    raise = 1'b0;
    // Prefetch tag errors are logged silently; no data was consumed
    if (l2_err.valid && l2_err.not_corrected_flag && !l2_prefetch) begin
      raise = 1'b1;
    end
    if (demand_hit_bad) begin
      raise = 1'b1;
    end
    if (l1_err.valid && l1_err.not_corrected_flag) begin
      raise = 1'b1;
    end
    if (b2_err.valid && b2_err.not_corrected_flag && (ctl_ff[2] != '0)) begin
      raise = 1'b1;
    end
    if (io_data_bad || l2_multi_tag) begin
      raise = 1'b1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_clr_cnt = clr_cnt_ff;
    nxt_mce = 1'b0;
    nxt_shared_out = shared_err_out_ff;
    nxt_smi_pend = smi_pend_ff;
    if (smi_req) begin
      nxt_smi_pend = 1'b1;
    end
    case (state_ff)
      mcb_pkg::MCB_CLEAR: begin
        nxt_clr_cnt = clr_cnt_ff + 8'h01;
        if (clr_cnt_ff == 8'(CLEAR_CYCLES - 1)) begin
          nxt_state = mcb_pkg::MCB_RUN;
        end
      end
      mcb_pkg::MCB_RUN: begin
        if (mce_en_ff && (raise || shared_err_in)) begin
          nxt_mce = 1'b1;
          nxt_shared_out = raise;
          nxt_state = mcb_pkg::MCB_HANDLER;
        end else if (smi_pend_ff && smi_taken) begin
          nxt_smi_pend = smi_req;
        end
      end
      mcb_pkg::MCB_HANDLER: begin
        // Interrupt stays pending for the whole handler
        if (handler_done) begin
          nxt_state = mcb_pkg::MCB_RUN;
          nxt_shared_out = 1'b0;
        end
      end
      default: nxt_state = mcb_pkg::MCB_CLEAR;
    endcase
    nxt_clear_busy = (nxt_state == mcb_pkg::MCB_CLEAR);
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < mcb_pkg::NUM_BANKS; b++) begin
      nxt_ctl[b] = ctl_ff[b];
      if (reg_wr && is_ofs(reg_addr, ctl_ofs(b))) begin
        nxt_ctl[b] = reg_wdata;
      end
    end
    nxt_mce_en = mce_en_ff;
    if (reg_wr && is_ofs(reg_addr, mcb_pkg::OFS_GLOBAL)) begin
      nxt_mce_en = reg_wdata[mcb_pkg::GLB_MCE_EN];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int b = 0; b < mcb_pkg::NUM_BANKS; b++) begin
        ctl_ff[b] <= mcb_pkg::CTL_RESET;
      end
      mce_en_ff <= 1'b0;
    end else begin
      for (int b = 0; b < mcb_pkg::NUM_BANKS; b++) begin
        ctl_ff[b] <= nxt_ctl[b];
      end
      mce_en_ff <= nxt_mce_en;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Zero outside the answering cycle, so a late sample never passes for a fresh answer
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        mcb_pkg::OFS_BANK0_CTL: nxt_rdata = ctl_ff[0];
        mcb_pkg::OFS_BANK0_STAT_LO: nxt_rdata = stat[0][31:0];
        mcb_pkg::OFS_BANK0_STAT_HI: nxt_rdata = stat[0][63:32];
        mcb_pkg::OFS_BANK1_CTL: nxt_rdata = ctl_ff[1];
        mcb_pkg::OFS_BANK1_STAT_LO: nxt_rdata = stat[1][31:0];
        mcb_pkg::OFS_BANK1_STAT_HI: nxt_rdata = stat[1][63:32];
        mcb_pkg::OFS_BANK1_ADDR_LO: nxt_rdata = addr[1][31:0];
        mcb_pkg::OFS_BANK1_ADDR_HI: nxt_rdata = 32'(addr[1][ADDR_W-1:32]);
        mcb_pkg::OFS_BANK2_CTL: nxt_rdata = ctl_ff[2];
        mcb_pkg::OFS_BANK2_STAT_LO: nxt_rdata = stat[2][31:0];
        mcb_pkg::OFS_BANK2_STAT_HI: nxt_rdata = stat[2][63:32];
        mcb_pkg::OFS_GLOBAL: begin
          nxt_rdata[mcb_pkg::GLB_MCE_EN] = mce_en_ff;
          nxt_rdata[mcb_pkg::GLB_IN_HANDLER] = (state_ff == mcb_pkg::MCB_HANDLER);
          nxt_rdata[mcb_pkg::GLB_SMI_PEND] = smi_pend_ff;
          nxt_rdata[mcb_pkg::GLB_CLEAR_BUSY] = clearing;
        end
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= 32'h00000000;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Bus queue retirement
  // ---------------------------------------------------------------
  // A snoop-deferred transfer that failed hard will never bring data, so it is
  // retired at once rather than left to block the bus queue
  always_comb begin
    nxt_retire = hard_fail && hard_fail_deferred;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      queue_retire_ff <= 1'b0;
    end else begin
      queue_retire_ff <= nxt_retire;
    end
  end

  // ---------------------------------------------------------------
  // Control state registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= mcb_pkg::MCB_CLEAR;
      clr_cnt_ff <= 8'h00;
      mce_ff <= 1'b0;
      smi_pend_ff <= 1'b0;
      shared_err_out_ff <= 1'b0;
      clear_busy_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      clr_cnt_ff <= nxt_clr_cnt;
      mce_ff <= nxt_mce;
      smi_pend_ff <= nxt_smi_pend;
      shared_err_out_ff <= nxt_shared_out;
      clear_busy_ff <= nxt_clear_busy;
    end
  end
endmodule

// ### verification/mcb_bus_model.sv
// Model of the other bus agents: hard failure responses and the shared error line
`timescale 1ns/100ps
module mcb_bus_model (
  input wire logic clock,           // Core clock
  input wire logic rstn,            // Async reset, active low
  output logic hard_fail,           // Hard failure response
  output logic hard_fail_deferred,  // Response belongs to a snoop-deferred transfer
  output logic shared_err_in        // Shared error level from another processor
);
  logic fail_req = 1'b0;
  logic fail_def = 1'b0;
  initial begin
    hard_fail = 1'b0;
    hard_fail_deferred = 1'b0;
    shared_err_in = 1'b0;
  end
  // Qualifier means nothing outside a response, so it toggles to expose misuse
  always @(posedge clock) begin
    hard_fail <= fail_req;
    hard_fail_deferred <= fail_req ? fail_def : ~hard_fail_deferred;
    fail_req <= 1'b0;
  end
  // Returns once the block has sampled the response
  task automatic fail(input logic def, input int delay);
    repeat (delay) @(posedge clock);
    #1 fail_req = 1'b1;
    fail_def = def;
    @(posedge clock);
    @(posedge clock);
    #1;
  endtask
  // Another processor raises the shared error line for one cycle
  task automatic shared();
    @(posedge clock);
    shared_err_in <= 1'b1;
    @(posedge clock);
    shared_err_in <= 1'b0;
    #1;
  endtask
endmodule

// ### verification/mcb_top_sva.sv
// Concurrent checks on the machine-check error bank top ports
`timescale 1ns/100ps
module mcb_top_sva #(
  parameter int CLEAR_CYCLES = 8
) (
  input wire logic clock,               // Core clock
  input wire logic rstn,                // Async reset, active low
  input wire logic [3:0] reg_addr,      // Register word index
  input wire logic [31:0] reg_wdata,    // Register write data
  input wire logic reg_wr,              // Write strobe
  input wire logic io_data_bad,         // I/O data corrupted
  input wire logic demand_hit_bad,      // Demand access hit poisoned line
  input wire logic l2_multi_tag,        // Multiple tag match
  input wire logic hard_fail,           // Hard failure response
  input wire logic hard_fail_deferred,  // Deferred qualifier
  input wire logic handler_done,        // Handler returned
  input wire logic mce_ff,              // Exception pulse
  input wire logic smi_pend_ff,         // Interrupt pending
  input wire logic queue_retire_ff,     // Retire pulse
  input wire logic shared_err_out_ff,   // Shared error drive
  input wire logic clear_busy_ff        // Clearing in progress
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic en_ff;
  logic in_h_ff;
  logic [7:0] cnt_ff;
  logic ready;
  // Shadows of enable and handler state, so causes can be tied to the pulse
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en_ff <= 1'b0;
      in_h_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == mcb_pkg::OFS_GLOBAL) en_ff <= reg_wdata[mcb_pkg::GLB_MCE_EN];
      if (mce_ff) in_h_ff <= 1'b1;
      else if (handler_done) in_h_ff <= 1'b0;
      if (clear_busy_ff) cnt_ff <= cnt_ff + 8'h01;
    end
  end
  assign ready = en_ff && !in_h_ff && !mce_ff && !clear_busy_ff;
  AST_RETIRE: assert property (hard_fail && hard_fail_deferred && !clear_busy_ff |=> queue_retire_ff)
    else $error("deferred hard failure not retired");
  AST_RETIRE_CAUSE: assert property (queue_retire_ff |-> $past(hard_fail) && $past(hard_fail_deferred))
    else $error("retire without deferred hard failure");
  AST_IO_RAISE: assert property (io_data_bad && ready |=> mce_ff)
    else $error("corrupt I/O data raised no exception");
  AST_DEMAND_RAISE: assert property (demand_hit_bad && ready |=> mce_ff)
    else $error("demand access to bad line raised no exception");
  AST_MULTI_TAG_RAISE: assert property (l2_multi_tag && ready |=> mce_ff)
    else $error("multiple tag match raised no exception");
  AST_SMI_HELD: assert property (smi_pend_ff && (in_h_ff || mce_ff) |=> smi_pend_ff)
    else $error("pending interrupt dropped inside handler");
  AST_NO_MCE_CLEARING: assert property (clear_busy_ff |-> !mce_ff)
    else $error("exception during bank clearing");
  AST_CLEAR_LEN: assert property ($fell(clear_busy_ff) |-> cnt_ff == CLEAR_CYCLES)
    else $error("clearing length wrong");
  AST_SHARED_LOCAL: assert property ($rose(shared_err_out_ff) |-> mce_ff)
    else $error("shared error driven without exception");
  AST_SHARED_END: assert property (shared_err_out_ff && handler_done |=> !shared_err_out_ff)
    else $error("shared error held after handler return");
  COV_MCE_SMI: cover property (mce_ff && smi_pend_ff);
  COV_RETIRE: cover property (queue_retire_ff);
  COV_CLEAR_END: cover property ($fell(clear_busy_ff));
endmodule
bind mcb_top mcb_top_sva #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_sva (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .io_data_bad(io_data_bad), .demand_hit_bad(demand_hit_bad),
  .l2_multi_tag(l2_multi_tag), .hard_fail(hard_fail), .hard_fail_deferred(hard_fail_deferred),
  .handler_done(handler_done), .mce_ff(mce_ff), .smi_pend_ff(smi_pend_ff), .queue_retire_ff(queue_retire_ff),
  .shared_err_out_ff(shared_err_out_ff), .clear_busy_ff(clear_busy_ff));

// ### verification/testbench.sv
// Self-checking bench for the machine-check error bank
`timescale 1ns/100ps
module testbench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0, l2_prefetch = 1'b0, io_data_bad = 1'b0, demand_hit_bad = 1'b0;
  logic l2_multi_tag = 1'b0, smi_req = 1'b0, smi_taken = 1'b0, handler_done = 1'b0;
  logic [39:0] multi_tag_addr = 40'h0;
  mcb_pkg::mcb_err_t l2_err = '0, l1_err = '0, b2_err = '0;
  logic [31:0] reg_rdata_ff;
  logic mce_ff, smi_pend_ff, queue_retire_ff, shared_err_out_ff, clear_busy_ff, hard_fail, hard_fail_deferred;
  logic shared_err_in;
  int mismatches = 0, total_checks = 0;
  always #50 clock = ~clock;
  mcb_top uut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .l2_err(l2_err), .l2_prefetch(l2_prefetch), .l2_multi_tag(l2_multi_tag),
    .multi_tag_addr(multi_tag_addr), .l1_err(l1_err), .b2_err(b2_err), .io_data_bad(io_data_bad),
    .demand_hit_bad(demand_hit_bad), .hard_fail(hard_fail), .hard_fail_deferred(hard_fail_deferred),
    .smi_req(smi_req), .smi_taken(smi_taken), .handler_done(handler_done), .shared_err_in(shared_err_in),
    .reg_rdata_ff(reg_rdata_ff), .mce_ff(mce_ff), .smi_pend_ff(smi_pend_ff), .queue_retire_ff(queue_retire_ff),
    .shared_err_out_ff(shared_err_out_ff), .clear_busy_ff(clear_busy_ff));
  mcb_bus_model far (.clock(clock), .rstn(rstn), .hard_fail(hard_fail), .hard_fail_deferred(hard_fail_deferred),
    .shared_err_in(shared_err_in));
  // ----------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask
  function automatic mcb_pkg::mcb_err_t mk(logic h, logic u, logic [15:0] c, logic [39:0] a);
    mk = '{valid: 1'b1, not_corrected_flag: u, context_corrupt_flag: u, second_half: h, addr_ok: 1'b1, code: c, addr: a};
  endfunction
  task automatic fire(input int b, input mcb_pkg::mcb_err_t e);
    @(posedge clock);
    if (b == 0) l2_err <= e;
    else if (b == 1) l1_err <= e;
    else b2_err <= e;
    @(posedge clock);
    {l2_err, l1_err, b2_err} <= '0;
    #1;
  endtask
  // Mask order: io, demand, multi tag, smi request, smi taken, handler done
  task automatic pulse(input logic [5:0] m);
    @(posedge clock);
    {io_data_bad, demand_hit_bad, l2_multi_tag, smi_req, smi_taken, handler_done} <= m;
    @(posedge clock);
    {io_data_bad, demand_hit_bad, l2_multi_tag, smi_req, smi_taken, handler_done} <= 6'h0;
    #1;
  endtask
  task automatic reset_and_clear();
    rstn <= 1'b0;
    repeat (16) @(posedge clock);
    chk("busy in reset", {31'h0, clear_busy_ff}, 32'h1);
    rstn <= 1'b1;
    rd(mcb_pkg::OFS_GLOBAL);
    chk("global clearing", d, 32'h8);
    for (int i = 0; i < 20 && clear_busy_ff !== 1'b0; i++) @(posedge clock);
    rd(mcb_pkg::OFS_GLOBAL);
    chk("global after clear", d, 32'h0);
    rd(mcb_pkg::OFS_BANK0_STAT_HI);
    chk("bank0 cleared", d, 32'h0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Logging table: bank, half, uncor1, two reports, uncor2, valid/over/not_corrected_flag
  // ----------------------------------------
  typedef struct packed {logic [1:0] b; logic h; logic u1; logic two; logic u2; logic [2:0] e;} mcb_row_t;
  mcb_row_t rows [6] = '{'{2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h4}, '{2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 3'h6},
    '{2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h6}, '{2'h0, 1'h0, 1'h1, 1'h1, 1'h0, 3'h7},
    '{2'h1, 1'h0, 1'h0, 1'h1, 1'h0, 3'h6}, '{2'h2, 1'h0, 1'h0, 1'h1, 1'h1, 3'h7}};
  logic [3:0] lo_ofs [3] = '{mcb_pkg::OFS_BANK0_STAT_LO, mcb_pkg::OFS_BANK1_STAT_LO, mcb_pkg::OFS_BANK2_STAT_LO};
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    end_of_test();
  end
  initial begin
    reset_and_clear();
    rd(mcb_pkg::OFS_BANK2_CTL);
    chk("ctl reset", d, mcb_pkg::CTL_RESET);
    rd(4'hc);
    chk("unmapped", d, 32'h0);
    foreach (rows[i]) begin
      wr(lo_ofs[rows[i].b], 32'h0);
      wr(lo_ofs[rows[i].b] + 4'h1, 32'h0);
      fire(rows[i].b, mk(rows[i].h, rows[i].u1, 16'h00a1, 40'h0));
      if (rows[i].two) fire(rows[i].b, mk(1'b0, rows[i].u2, 16'h00b2, 40'h0));
      rd(lo_ofs[rows[i].b] + 4'h1);
      chk("status flags", {29'h0, d[31:29]}, {29'h0, rows[i].e});
      rd(lo_ofs[rows[i].b]);
      chk("status code", {16'h0, d[15:0]}, (rows[i].two && !rows[i].u1) ? 32'hb2 : 32'ha1);
    end
    // ----------------------------------------
    // Hand-written cases
    // ----------------------------------------
    wr(mcb_pkg::OFS_BANK1_STAT_HI, 32'h0);
    fire(1, mk(1'b0, 1'b1, 16'h00a1, 40'h12_3456_789a));
    fire(1, mk(1'b0, 1'b0, 16'h00b2, 40'h00_0bad_0bad));
    rd(mcb_pkg::OFS_BANK1_ADDR_LO);
    chk("l1 addr lo", d, 32'h3456789a);
    rd(mcb_pkg::OFS_BANK1_ADDR_HI);
    chk("l1 addr hi", d, 32'h12);
    wr(mcb_pkg::OFS_GLOBAL, 32'h1);
    pulse(6'h24);
    chk("io mce", {30'h0, mce_ff, smi_pend_ff}, 32'h3);
    chk("shared out", {31'h0, shared_err_out_ff}, 32'h1);
    pulse(6'h02);
    chk("smi held", {31'h0, smi_pend_ff}, 32'h1);
    pulse(6'h01);
    chk("shared end", {31'h0, shared_err_out_ff}, 32'h0);
    pulse(6'h02);
    chk("smi taken", {31'h0, smi_pend_ff}, 32'h0);
    wr(mcb_pkg::OFS_BANK2_CTL, 32'h0);
    wr(mcb_pkg::OFS_BANK2_STAT_HI, 32'h0);
    fire(2, mk(1'b0, 1'b1, 16'h00c3, 40'h0));
    chk("bank2 off mce", {31'h0, mce_ff}, 32'h0);
    rd(mcb_pkg::OFS_BANK2_STAT_HI);
    chk("bank2 off log", {30'h0, d[31], d[29]}, 32'h3);
    wr(mcb_pkg::OFS_BANK2_CTL, mcb_pkg::CTL_RESET);
    fire(2, mk(1'b0, 1'b1, 16'h00c3, 40'h0));
    chk("bank2 on mce", {31'h0, mce_ff}, 32'h1);
    pulse(6'h01);
    l2_prefetch <= 1'b1;
    fire(0, mk(1'b0, 1'b1, 16'h00d4, 40'h0));
    l2_prefetch <= 1'b0;
    chk("prefetch mce", {31'h0, mce_ff}, 32'h0);
    pulse(6'h10);
    chk("demand mce", {31'h0, mce_ff}, 32'h1);
    pulse(6'h01);
    wr(mcb_pkg::OFS_BANK0_STAT_HI, 32'h0);
    multi_tag_addr <= 40'h00_0000_5a00;
    pulse(6'h08);
    chk("multi tag mce", {31'h0, mce_ff}, 32'h1);
    pulse(6'h01);
    rd(mcb_pkg::OFS_BANK0_STAT_HI);
    chk("multi tag log", {30'h0, d[31], d[29]}, 32'h3);
    far.shared();
    chk("remote mce", {30'h0, mce_ff, shared_err_out_ff}, 32'h2);
    pulse(6'h01);
    far.fail(1'b1, 0);
    chk("retire prompt", {31'h0, queue_retire_ff}, 32'h1);
    far.fail(1'b1, 5);
    chk("retire slow", {31'h0, queue_retire_ff}, 32'h1);
    far.fail(1'b0, 2);
    chk("no retire plain", {31'h0, queue_retire_ff}, 32'h0);
    reset_and_clear();
    end_of_test();
  end
endmodule
